// [core/fpwp_flash_prog.sv]
/*
 * Flash program data registers, unlock key and page write protection,
 * reached over AXI4-Lite, launching requests to the flash array.
 * Assumes por_n and fl_done are synchronous to aclk; por_n low implies a
 * power-on reset, aresetn low any reset.
 */
`include "fpwp_regs.svh"

// Functional notes
// - Word program writes data word zero to the target address.
// - Quad program writes data words three..zero, word zero lowest.
// - Data and source registers are read/write, cleared only at power-on.
// - Row program fetches data from the source address register.
// - Main unlock bit one allows main protect changes, zero locks them.
// - Main unlock bit is clear-only; only reset sets it again.
// - Main flash below 0x1D prefix plus boundary is program/erase blocked.
// - A zero boundary disables main flash protection entirely.
// - A boundary inside a page protects that whole page and below; the code drops bits 13..0 and protects only the pages below that page.
// - Lower boot unlock bit 15 gates lower page bits; clear-only.
// - Upper boot unlock bit 7 gates upper page bits; clear-only.
// - Lower boot bits 8..12 each guard one 16 KB page.
// - Upper boot bits 0..4 each guard one 16 KB page.
// - Boot page bits change only after key and with unlock bit set.
// - Boot protect bit 6 is reserved and reads one.
// - Operation codes: none 0000, word 0001, quad 0010, row 0011.
// - Key register is write-only and always reads zero.
// - Run bit sets only with write enable and key; software cannot clear.
module fpwp_flash_prog (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic fl_req,
	output logic [3:0] fl_op,
	output logic [31:0] fl_addr,
	output logic [127:0] fl_wdata,
	output logic [31:0] fl_src_addr,
	output logic fl_blocked,
	input wire logic fl_done
);
	// Bus state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	// Register state
	logic [3:0] op_q, op_d;
	logic wen_q, wen_d;
	logic key_stage_q, key_stage_d, unlocked_q, unlocked_d;
	logic [31:0] taddr_q, taddr_d, src_q, src_d;
	logic [31:0] data_q [4];
	logic [31:0] data_d [4];
	logic mp_unlock_q, mp_unlock_d, lb_unlock_q, lb_unlock_d;
	logic ub_unlock_q, ub_unlock_d;
	logic [9:0] mp_bound_q, mp_bound_d;
	logic [4:0] lb_prot_q, lb_prot_d, ub_prot_q, ub_prot_d;
	// Flash request state
	fpwp_pkg::fpwp_state_t state_q, state_d;
	logic [3:0] fl_op_q, fl_op_d;
	logic [31:0] fl_addr_q, fl_addr_d, fl_src_q, fl_src_d;
	logic [127:0] fl_wdata_q, fl_wdata_d;
	logic fl_blocked_q, fl_blocked_d;
	// Decode helpers
	logic do_wr, go, main_hit, boot_hit;
	logic [31:0] wd, cur, rd_val;
	logic rd_ok;
	logic [23:0] bound_full;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	assign bound_full = {mp_bound_q, 14'h0000};

	fpwp_page_guard u_guard (
		.addr(taddr_q),
		.bound(bound_full),
		.low_prot(lb_prot_q),
		.up_prot(ub_prot_q),
		.main_hit(main_hit),
		.boot_hit(boot_hit)
	);

	assign awready = !aw_have_q && !bvalid_q;
	assign wready = !w_have_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign fl_req = (state_q == fpwp_pkg::fpwp_busy);
	assign fl_op = fl_op_q;
	assign fl_addr = fl_addr_q;
	assign fl_wdata = fl_wdata_q;
	assign fl_src_addr = fl_src_q;
	assign fl_blocked = fl_blocked_q;
	assign do_wr = aw_have_q && w_have_q && !bvalid_q;

	// Read view of every register
	always_comb begin
		rd_ok = 1'b1;
		case (araddr)
			`FPWP_OFS_CTRL: rd_val = {16'h0000, fl_req, wen_q, 10'h000, op_q};
			`FPWP_OFS_KEY: rd_val = 32'h0000_0000;
			`FPWP_OFS_TADDR: rd_val = taddr_q;
			`FPWP_OFS_DATA0: rd_val = data_q[0];
			`FPWP_OFS_DATA1: rd_val = data_q[1];
			`FPWP_OFS_DATA2: rd_val = data_q[2];
			`FPWP_OFS_DATA3: rd_val = data_q[3];
			`FPWP_OFS_SRC: rd_val = src_q;
			`FPWP_OFS_MPROT: rd_val = {mp_unlock_q, 7'h00, bound_full};
			`FPWP_OFS_BPROT: rd_val = {16'h0000, lb_unlock_q, 2'b00,
				lb_prot_q, ub_unlock_q, 1'b1, 1'b0, ub_prot_q};
			default: begin
				rd_val = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d = w_have_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		op_d = op_q;
		wen_d = wen_q;
		key_stage_d = key_stage_q;
		unlocked_d = unlocked_q;
		taddr_d = taddr_q;
		src_d = src_q;
		data_d = data_q;
		mp_unlock_d = mp_unlock_q;
		mp_bound_d = mp_bound_q;
		lb_unlock_d = lb_unlock_q;
		lb_prot_d = lb_prot_q;
		ub_unlock_d = ub_unlock_q;
		ub_prot_d = ub_prot_q;
		state_d = state_q;
		fl_op_d = fl_op_q;
		fl_addr_d = fl_addr_q;
		fl_src_d = fl_src_q;
		fl_wdata_d = fl_wdata_q;
		fl_blocked_d = 1'b0;
		go = 1'b0;
		cur = 32'h0000_0000;
		if (awvalid && awready) begin
			aw_have_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_have_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rdata_d = rd_val;
			rresp_d = rd_ok ? `FPWP_RESP_OKAY : `FPWP_RESP_SLVERR;
		end
		case (aw_addr_q)
			`FPWP_OFS_TADDR: cur = taddr_q;
			`FPWP_OFS_DATA0: cur = data_q[0];
			`FPWP_OFS_DATA1: cur = data_q[1];
			`FPWP_OFS_DATA2: cur = data_q[2];
			`FPWP_OFS_DATA3: cur = data_q[3];
			`FPWP_OFS_SRC: cur = src_q;
			default: cur = 32'h0000_0000;
		endcase
		wd = merge(cur, w_data_q, w_strb_q);
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `FPWP_RESP_OKAY;
			// Every write spends the unlock; only the second key sets it again
			key_stage_d = 1'b0;
			unlocked_d = 1'b0;
			case (aw_addr_q)
				`FPWP_OFS_CTRL: begin
					if (!wen_q) begin
						op_d = wd[`FPWP_CTRL_OP_MSB:`FPWP_CTRL_OP_LSB];
					end
					wen_d = wd[`FPWP_CTRL_WEN];
					go = wd[`FPWP_CTRL_RUN] && wen_q && unlocked_q
						&& (state_q == fpwp_pkg::fpwp_idle);
				end
				`FPWP_OFS_KEY: begin
					if (w_data_q == `FPWP_KEY_FIRST) begin
						key_stage_d = 1'b1;
					end else if (key_stage_q && w_data_q == `FPWP_KEY_SECOND) begin
						unlocked_d = 1'b1;
					end
				end
				`FPWP_OFS_TADDR: taddr_d = wd;
				`FPWP_OFS_DATA0: data_d[0] = wd;
				`FPWP_OFS_DATA1: data_d[1] = wd;
				`FPWP_OFS_DATA2: data_d[2] = wd;
				`FPWP_OFS_DATA3: data_d[3] = wd;
				`FPWP_OFS_SRC: src_d = wd;
				`FPWP_OFS_MPROT: begin
					if (unlocked_q && mp_unlock_q) begin
						mp_bound_d = wd[`FPWP_MP_BOUND_MSB:`FPWP_MP_BOUND_LSB];
						mp_unlock_d = wd[`FPWP_MP_UNLOCK];
					end
				end
				`FPWP_OFS_BPROT: begin
					if (unlocked_q && lb_unlock_q) begin
						lb_prot_d = wd[`FPWP_BP_LOW_MSB:`FPWP_BP_LOW_LSB];
						lb_unlock_d = wd[`FPWP_BP_LOW_UNLOCK];
					end
					if (unlocked_q && ub_unlock_q) begin
						ub_prot_d = wd[`FPWP_BP_UP_MSB:`FPWP_BP_UP_LSB];
						ub_unlock_d = wd[`FPWP_BP_UP_UNLOCK];
					end
				end
				default: bresp_d = `FPWP_RESP_SLVERR;
			endcase
		end
		case (state_q)
			fpwp_pkg::fpwp_idle: begin
				if (go && op_q != fpwp_pkg::fpwp_op_none) begin
					if (main_hit || boot_hit) begin
						fl_blocked_d = 1'b1;
					end else begin
						state_d = fpwp_pkg::fpwp_busy;
						fl_op_d = op_q;
						fl_addr_d = taddr_q;
						fl_src_d = src_q;
						if (op_q == fpwp_pkg::fpwp_op_word) begin
							fl_wdata_d = {96'h0, data_q[0]};
						end else begin
							fl_wdata_d = {data_q[3], data_q[2], data_q[1],
								data_q[0]};
						end
					end
				end
			end
			fpwp_pkg::fpwp_busy: begin
				if (fl_done) begin
					state_d = fpwp_pkg::fpwp_idle;
				end
			end
			default: state_d = fpwp_pkg::fpwp_idle;
		endcase
	end

	// Bus and request state follow every reset
	always_ff @(posedge aclk) begin
		if (!aresetn || !por_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_have_q <= 1'b0;
			w_data_q <= `FPWP_RST_WORD;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `FPWP_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= `FPWP_RST_WORD;
			rresp_q <= `FPWP_RESP_OKAY;
			key_stage_q <= 1'b0;
			unlocked_q <= 1'b0;
			state_q <= fpwp_pkg::fpwp_idle;
			fl_op_q <= 4'h0;
			fl_addr_q <= `FPWP_RST_WORD;
			fl_src_q <= `FPWP_RST_WORD;
			fl_wdata_q <= 128'h0;
			fl_blocked_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q <= w_have_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			key_stage_q <= key_stage_d;
			unlocked_q <= unlocked_d;
			state_q <= state_d;
			fl_op_q <= fl_op_d;
			fl_addr_q <= fl_addr_d;
			fl_src_q <= fl_src_d;
			fl_wdata_q <= fl_wdata_d;
			fl_blocked_q <= fl_blocked_d;
		end
	end

	// Contents cleared by power-on only; other resets hold them
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			op_q <= 4'h0;
			wen_q <= 1'b0;
			taddr_q <= `FPWP_RST_WORD;
			src_q <= `FPWP_RST_WORD;
			data_q <= '{default: `FPWP_RST_WORD};
			mp_bound_q <= `FPWP_RST_BOUND;
			lb_prot_q <= `FPWP_RST_BOOT_PAGES;
			ub_prot_q <= `FPWP_RST_BOOT_PAGES;
		end else begin
			op_q <= op_d;
			wen_q <= wen_d;
			taddr_q <= taddr_d;
			src_q <= src_d;
			data_q <= data_d;
			mp_bound_q <= mp_bound_d;
			lb_prot_q <= lb_prot_d;
			ub_prot_q <= ub_prot_d;
		end
	end

	// Unlock bits are set by any reset
	always_ff @(posedge aclk) begin
		if (!aresetn || !por_n) begin
			mp_unlock_q <= 1'b1;
			lb_unlock_q <= 1'b1;
			ub_unlock_q <= 1'b1;
		end else begin
			mp_unlock_q <= mp_unlock_d && mp_unlock_q;
			lb_unlock_q <= lb_unlock_d && lb_unlock_q;
			ub_unlock_q <= ub_unlock_d && ub_unlock_q;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !por_n);

	word_launch_a: assert property (go && !fl_req && !main_hit && !boot_hit
		&& op_q == fpwp_pkg::fpwp_op_word |=> fl_req
		&& fl_wdata == {96'h0, $past(data_q[0])} && fl_addr == $past(taddr_q))
		else $error("word program data or address wrong");
	quad_launch_a: assert property (go && !fl_req && !main_hit && !boot_hit
		&& op_q == fpwp_pkg::fpwp_op_quad |=> fl_wdata == {$past(data_q[3]),
		$past(data_q[2]), $past(data_q[1]), $past(data_q[0])})
		else $error("quad program data order wrong");
	row_source_a: assert property (go && !fl_req && !main_hit && !boot_hit
		&& op_q == fpwp_pkg::fpwp_op_row |=> fl_src_addr == $past(src_q))
		else $error("row program source address wrong");
	main_lock_a: assert property (!mp_unlock_q |=> $stable(mp_bound_q))
		else $error("locked main protect changed");
	unlock_sticky_a: assert property (!mp_unlock_q ##1 1'b1
		|-> !mp_unlock_q) else $error("main unlock bit set by software");
	boot_lock_a: assert property (!lb_unlock_q && !ub_unlock_q
		|=> $stable(lb_prot_q) && $stable(ub_prot_q) && !lb_unlock_q)
		else $error("locked boot protect changed");
	zero_bound_a: assert property (mp_bound_q == 10'h000 |-> !main_hit)
		else $error("zero boundary still protects");
	blocked_req_a: assert property (go && (main_hit || boot_hit)
		&& op_q != 4'h0 && !fl_req |=> !fl_req && fl_blocked)
		else $error("protected page issued");
	run_hold_a: assert property (fl_req && !fl_done |=> fl_req)
		else $error("run bit dropped before completion");
	key_read_a: assert property (arvalid && arready
		&& araddr == `FPWP_OFS_KEY |=> rvalid && rdata == 32'h0000_0000)
		else $error("key register read nonzero");
	boot_rsvd_a: assert property (arvalid && arready
		&& araddr == `FPWP_OFS_BPROT |=> rdata[`FPWP_BP_RSVD])
		else $error("reserved boot bit not one");

endmodule : fpwp_flash_prog

// [core/fpwp_page_guard.sv]
/*
 * Decides whether a physical flash address lies in a write-protected page.
 * Assumes 16 KB pages and boundary bits below the page index read as zero.
 */
`include "fpwp_regs.svh"

module fpwp_page_guard (
	input wire logic [31:0] addr,
	input wire logic [23:0] bound,
	input wire logic [4:0] low_prot,
	input wire logic [4:0] up_prot,
	output logic main_hit,
	output logic boot_hit
);
	logic [23:0] last_prot;
	logic [2:0] page;

	always_comb begin
		last_prot = bound - 24'h00_0001;
		page = addr[16:14];
		// Page holding the byte just below the boundary and all below it
		main_hit = (addr[31:24] == `FPWP_MAIN_PREFIX) && (bound != 24'h00_0000)
			&& (addr[23:14] <= last_prot[23:14]);
		boot_hit = 1'b0;
		if (page < `FPWP_BOOT_PAGES) begin
			if (addr[31:17] == `FPWP_BOOT_LOW_TAG) begin
				boot_hit = low_prot[page];
			end else if (addr[31:17] == `FPWP_BOOT_UP_TAG) begin
				boot_hit = up_prot[page];
			end
		end
	end

endmodule : fpwp_page_guard

// [inc/fpwp_pkg.sv]
/*
 * Types shared by the flash program data and write-protect block.
 * Assumes nothing of its surroundings.
 */
package fpwp_pkg;

	typedef enum logic [3:0] {
		fpwp_op_none = 4'h0,
		fpwp_op_word = 4'h1,
		fpwp_op_quad = 4'h2,
		fpwp_op_row = 4'h3
	} fpwp_op_t;

	typedef enum logic [0:0] {
		fpwp_idle = 1'b0,
		fpwp_busy = 1'b1
	} fpwp_state_t;

endpackage : fpwp_pkg

// [inc/fpwp_regs.svh]
/*
 * Register offsets, field positions, reset values and region constants
 * for the flash program data and write-protect block.
 * Assumes an 8-bit AXI4-Lite byte address and 32-bit data.
 */
`ifndef FPWP_REGS_SVH
`define FPWP_REGS_SVH

`define FPWP_OFS_CTRL 8'h00
`define FPWP_OFS_KEY 8'h04
`define FPWP_OFS_TADDR 8'h08
`define FPWP_OFS_DATA0 8'h0C
`define FPWP_OFS_DATA1 8'h10
`define FPWP_OFS_DATA2 8'h14
`define FPWP_OFS_DATA3 8'h18
`define FPWP_OFS_SRC 8'h1C
`define FPWP_OFS_MPROT 8'h20
`define FPWP_OFS_BPROT 8'h24

`define FPWP_CTRL_RUN 15
`define FPWP_CTRL_WEN 14
`define FPWP_CTRL_OP_MSB 3
`define FPWP_CTRL_OP_LSB 0

`define FPWP_MP_UNLOCK 31
`define FPWP_MP_BOUND_MSB 23
`define FPWP_MP_BOUND_LSB 14
`define FPWP_BP_LOW_UNLOCK 15
`define FPWP_BP_LOW_MSB 12
`define FPWP_BP_LOW_LSB 8
`define FPWP_BP_UP_UNLOCK 7
`define FPWP_BP_RSVD 6
`define FPWP_BP_UP_MSB 4
`define FPWP_BP_UP_LSB 0

`define FPWP_RST_WORD 32'h0000_0000
`define FPWP_RST_BOUND 10'h000
`define FPWP_RST_BOOT_PAGES 5'h1F

// Key values are arbitrary
`define FPWP_KEY_FIRST 32'h5A5A_0F0F
`define FPWP_KEY_SECOND 32'hA5A5_F0F0

`define FPWP_MAIN_PREFIX 8'h1D
`define FPWP_BOOT_LOW_TAG 15'h0FE0
`define FPWP_BOOT_UP_TAG 15'h0FE1
`define FPWP_BOOT_PAGES 3'h5

`define FPWP_RESP_OKAY 2'b00
`define FPWP_RESP_SLVERR 2'b10

`endif

// [testbench/flash_program_data_and_write_protect_test.sv]
/*
 * Self-checking bench for the flash program data and write-protect block.
 * Assumes fpwp_flash_prog and fpwp_regs.svh are compiled alongside.
 */
`include "fpwp_regs.svh"

module flash_program_data_and_write_protect_test;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [7:0] a;
		logic [31:0] wd;
		logic [31:0] rd;
		logic [1:0] rsp;
	} fpwp_row_t;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic por_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic fl_done = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, fl_req, fl_blocked;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, fl_addr, fl_src_addr, val;
	logic [3:0] fl_op;
	logic [127:0] fl_wdata;
	logic req_q = 1'b0;
	int err_count = 0;
	int n_compared = 0;
	int n_blk = 0;
	int n_req = 0;
	int cyc = 0;

	fpwp_row_t rows [8] = '{
		'{`FPWP_OFS_DATA0, 32'h1111_1111, 32'h1111_1111, `FPWP_RESP_OKAY},
		'{`FPWP_OFS_DATA1, 32'h2222_2222, 32'h2222_2222, `FPWP_RESP_OKAY},
		'{`FPWP_OFS_DATA2, 32'h3333_3333, 32'h3333_3333, `FPWP_RESP_OKAY},
		'{`FPWP_OFS_DATA3, 32'h4444_4444, 32'h4444_4444, `FPWP_RESP_OKAY},
		'{`FPWP_OFS_SRC, 32'h8000_1000, 32'h8000_1000, `FPWP_RESP_OKAY},
		'{`FPWP_OFS_TADDR, 32'h1D00_0000, 32'h1D00_0000, `FPWP_RESP_OKAY},
		'{`FPWP_OFS_KEY, 32'h1234_5678, 32'h0000_0000, `FPWP_RESP_OKAY},
		'{8'h30, 32'hFFFF_FFFF, 32'h0000_0000, `FPWP_RESP_SLVERR}
	};

	always #12.5 aclk = ~aclk;

	fpwp_flash_prog i_dut (
		.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .fl_src_addr(fl_src_addr),
		.fl_blocked(fl_blocked), .fl_done(fl_done)
	);

	// Counts refusals and launches; also cuts a hang short
	always @(posedge aclk) begin
		cyc++;
		if (fl_blocked === 1'b1) n_blk++;
		if (fl_req === 1'b1 && req_q !== 1'b1) n_req++;
		req_q = fl_req;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [127:0] e,
		input logic [127:0] g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_d;
		logic w_d;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_d = 1'b0;
		w_d = 1'b0;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_d = 1'b1;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_d = 1'b1;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		val = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		rd(a);
		check(nm, e, val);
	endtask : rdchk

	task automatic kwr(input logic [7:0] a, input logic [31:0] d);
		wr(`FPWP_OFS_KEY, `FPWP_KEY_FIRST);
		wr(`FPWP_OFS_KEY, `FPWP_KEY_SECOND);
		wr(a, d);
	endtask : kwr

	// Selects op with the gate low, raises the gate, then sets run
	task automatic launch(input logic [3:0] op, input logic [31:0] ta,
		input bit k, input bit blk);
		int b0;
		int r0;
		logic [31:0] o;
		logic [127:0] wd;
		b0 = n_blk;
		r0 = n_req;
		o = {28'h000_0000, op};
		wd = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
		if (op == 4'h1) wd = {96'h0, 32'h1111_1111};
		wr(`FPWP_OFS_TADDR, ta);
		wr(`FPWP_OFS_CTRL, o);
		wr(`FPWP_OFS_CTRL, o);
		wr(`FPWP_OFS_CTRL, 32'h0000_4000 | o);
		if (k) kwr(`FPWP_OFS_CTRL, 32'h0000_C000 | o);
		else wr(`FPWP_OFS_CTRL, 32'h0000_C000 | o);
		repeat (3) @(posedge aclk);
		check("blocked pulse", blk, n_blk - b0);
		check("flash request", !blk && k && op != 4'h0, n_req - r0);
		if (n_req != r0) begin
			check("op", op, fl_op);
			check("target", ta, fl_addr);
			check("data", wd, fl_wdata);
			if (op == 4'h3) check("source", 32'h8000_1000, fl_src_addr);
			wr(`FPWP_OFS_CTRL, 32'h0000_4000 | o);
			rdchk("run held", `FPWP_OFS_CTRL, 32'h0000_C000 | o);
			@(posedge aclk);
			fl_done <= 1'b1;
			@(posedge aclk);
			fl_done <= 1'b0;
			repeat (2) @(posedge aclk);
			check("request end", 1'b0, fl_req);
		end
		$display("done: launch op %0d at %h", op, ta);
	endtask : launch

	task automatic rst(input bit p);
		@(posedge aclk);
		aresetn <= 1'b0;
		if (p) por_n <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
	endtask : rst

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].wd);
			check("write response", rows[i].rsp, rsp);
			rd(rows[i].a);
			check("read data", rows[i].rd, val);
			check("read response", rows[i].rsp, rsp);
		end
		$display("done: register table");
		wr(`FPWP_OFS_MPROT, 32'h0000_8000);
		rdchk("main locked", `FPWP_OFS_MPROT, 32'h8000_0000);
		kwr(`FPWP_OFS_MPROT, 32'h8000_8000);
		rdchk("main set", `FPWP_OFS_MPROT, 32'h8000_8000);
		launch(4'h1, 32'h1D00_7FFC, 1, 1);
		launch(4'h1, 32'h1D00_8000, 1, 0);
		launch(4'h2, 32'h1D00_8010, 1, 0);
		launch(4'h3, 32'h1D00_9000, 1, 0);
		launch(4'h1, 32'h1D00_8000, 0, 0);
		launch(4'h0, 32'h1D00_8000, 1, 0);
		kwr(`FPWP_OFS_MPROT, 32'h0000_0000);
		rdchk("main clear", `FPWP_OFS_MPROT, 32'h0000_0000);
		kwr(`FPWP_OFS_MPROT, 32'h8000_C000);
		rdchk("main stuck", `FPWP_OFS_MPROT, 32'h0000_0000);
		launch(4'h1, 32'h1D00_0000, 1, 0);
		$display("done: main protection");
		launch(4'h1, 32'h1FC2_0000, 1, 1);
		kwr(`FPWP_OFS_BPROT, 32'h0000_8480);
		rdchk("boot set", `FPWP_OFS_BPROT, 32'h0000_84C0);
		launch(4'h1, 32'h1FC0_8000, 1, 1);
		launch(4'h1, 32'h1FC0_4000, 1, 0);
		launch(4'h1, 32'h1FC2_0000, 1, 0);
		kwr(`FPWP_OFS_BPROT, 32'h0000_0400);
		rdchk("boot lock", `FPWP_OFS_BPROT, 32'h0000_0440);
		kwr(`FPWP_OFS_BPROT, 32'h0000_9F9F);
		rdchk("boot stuck", `FPWP_OFS_BPROT, 32'h0000_0440);
		$display("done: boot protection");
		rst(0);
		rdchk("main after reset", `FPWP_OFS_MPROT, 32'h8000_0000);
		rdchk("boot after reset", `FPWP_OFS_BPROT, 32'h0000_84C0);
		rdchk("data kept", `FPWP_OFS_DATA3, 32'h4444_4444);
		// Two low byte lanes only
		wstrb <= 4'h3;
		wr(`FPWP_OFS_DATA3, 32'hABCD_EF01);
		wstrb <= 4'hF;
		rdchk("byte lanes", `FPWP_OFS_DATA3, 32'h4444_EF01);
		$display("done: plain reset");
		rst(1);
		rdchk("data cleared", `FPWP_OFS_DATA0, 32'h0000_0000);
		rdchk("source cleared", `FPWP_OFS_SRC, 32'h0000_0000);
		rdchk("boot at power on", `FPWP_OFS_BPROT, 32'h0000_9FDF);
		rdchk("main at power on", `FPWP_OFS_MPROT, 32'h8000_0000);
		$display("done: power-on reset");
		stop_test();
	end
endmodule : flash_program_data_and_write_protect_test
